// file: sfce_pkg.sv
// constants, opcodes and state types of the serial flash command engine
// Function
// - suspend during program or erase takes effect within 30 us, except on the final timer tick or during the erase sweep, where it is dropped.
// - page program covers up to 256 bytes, done within 3 ms.
// - all erases finish within 12 ms, typically 10 ms.
// - reads 0Bh with dummy and 03h without stream bytes until deselect.
// - dual reads 3Bh and BBh take address, dummy, then stream data.
// - quad reads 6Bh and EBh take address, dummy, then stream data.
// - opcode 20h with three address bytes erases a 4K sector.
// - opcode 52h with three address bytes erases a 32K block.
// - opcode D8h with three address bytes erases a 64K block.
// - opcode A2h programs a page from data taken on two lines.
// - opcode 32h programs a page from data taken on four lines.
// - opcode 06h sets the write enable latch.
// - opcode 04h clears the write enable latch.
// - opcode 50h lets the next status write change volatile bits.
// - opcode 48h streams the addressed security register contents.
// - opcode 05h returns the low status byte.
// - opcode 35h returns the high status byte.
// - latch clears at power-up and after each modifying command ends.
// - volatile status enable leaves the write enable latch untouched.
// - low status read gives bits 7..0, high gives 15..8, msb first.
package sfce_pkg;
  localparam real CLK_PERIOD_NS = 40.0;
  localparam real PAGE_PROG_MS = 1.3;
  localparam real PAGE_PROG_MAX_MS = 3.0;
  localparam real ERASE_MS = 10.0;
  localparam real ERASE_MAX_MS = 12.0;
  localparam int PROG_CYCLES = int'(PAGE_PROG_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int ERASE_CYCLES = int'(ERASE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int TMR_W = 18;
  localparam int MEM_AW = 10;
  localparam int MEM_BYTES = 1 << MEM_AW;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // lane widths
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;
  // opcodes
  localparam logic [7:0] OP_FAST_ARRAY_READ = 8'h0b;
  localparam logic [7:0] OP_SLOW_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_DUAL_PAGE_PROGRAM = 8'ha2;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_VOLATILE_STATUS_ENABLE = 8'h50;
  localparam logic [7:0] OP_SECURITY_REG_READ = 8'h48;
  localparam logic [7:0] OP_STATUS_LOW_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_HIGH_READ = 8'h35;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hb0;
  localparam logic [7:0] OP_RESUME_A = 8'h7a;
  localparam logic [7:0] OP_RESUME_B = 8'h30;
  // status word layout
  localparam int SR_WIP_BIT = 0;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_PSUS_BIT = 10;
  localparam int SR_ESUS_BIT = 15;
  localparam logic [15:0] SR_WR_MASK = 16'h7bfc;
  localparam logic [15:0] SR_RESET = 16'h0000;
  typedef enum {PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_END,
                PH_IGNORE} sfce_phase_t;
  typedef enum {BS_INIT, BS_IDLE, BS_PROG, BS_ERASE, BS_SWEEP} sfce_busy_t;
endpackage : sfce_pkg

// file: sfce_top.sv
// serial flash command engine: spi front end, decoder, array and timing
`timescale 1ns/10ps
module sfce_top #(
  parameter int PROG_TIME_CYCLES = sfce_pkg::PROG_CYCLES,
  parameter int ERASE_TIME_CYCLES = sfce_pkg::ERASE_CYCLES
) (
  // system
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // spi pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  import sfce_pkg::*;

  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic [3:0] io_s1_q, io_s2_q;

  sfce_phase_t phase_q;
  sfce_busy_t busy_q;
  logic [7:0] op_q, in_sr_q, out_sr_q;
  logic [2:0] in_w_q, out_w_q;
  logic [3:0] bitcnt_q;
  logic [1:0] cnt_q;
  logic [23:0] addr_q;
  logic dummy_q, ok_q, load_q;
  logic [15:0] sr_q, sr_new_q, status_w;
  logic wel_q, vol_q, susp_q;
  logic [TMR_W-1:0] timer_q;
  logic [MEM_AW-1:0] sweep_q;
  logic [7:0] mem_q [MEM_BYTES];
  logic [3:0] io_q, oe_q;

  // two-flop synchronisers, third stage only for edge finding
  always_ff @(posedge clk_i) begin
    cs_s1_q <= cs_n_i;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    sclk_s1_q <= sclk_i;
    sclk_s2_q <= sclk_s1_q;
    sclk_s3_q <= sclk_s2_q;
    io_s1_q <= io_i;
    io_s2_q <= io_s1_q;
  end

  wire cs_act = ~cs_s2_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;
  wire sclk_rise = cs_act & sclk_s2_q & ~sclk_s3_q;
  wire sclk_fall = cs_act & ~sclk_s2_q & sclk_s3_q;

  // input lanes: single on io0, dual {io1,io0}, quad io3..io0, msb first
  wire [7:0] in_next = (in_w_q == W4) ? {in_sr_q[3:0], io_s2_q} :
                       (in_w_q == W2) ? {in_sr_q[5:0], io_s2_q[1:0]} :
                       {in_sr_q[6:0], io_s2_q[0]};
  wire [3:0] in_cnt = bitcnt_q + {1'b0, in_w_q};
  wire [3:0] out_cnt = bitcnt_q + {1'b0, out_w_q};
  wire in_phase = (phase_q != PH_DOUT) && (phase_q != PH_IGNORE);
  wire byte_done = sclk_rise & in_phase & in_cnt[3];
  wire out_done = sclk_fall & (phase_q == PH_DOUT) & out_cnt[3];

  // status word seen by the host
  wire wip = (busy_q != BS_IDLE) & ~susp_q;
  always_comb begin
    status_w = sr_q & SR_WR_MASK;
    status_w[SR_WIP_BIT] = wip;
    status_w[SR_WEL_BIT] = wel_q;
    status_w[SR_PSUS_BIT] = susp_q & (busy_q == BS_PROG);
    status_w[SR_ESUS_BIT] = susp_q & (busy_q == BS_ERASE);
  end

  // opcode decode of the byte just shifted in
  wire [7:0] cb = in_next;
  wire c_rd1 = (cb == OP_FAST_ARRAY_READ) | (cb == OP_SECURITY_REG_READ);
  wire c_slow = cb == OP_SLOW_ARRAY_READ;
  wire c_rd2o = cb == OP_DUAL_OUTPUT_READ;
  wire c_rd2io = cb == OP_DUAL_IO_READ;
  wire c_rd4o = cb == OP_QUAD_OUTPUT_READ;
  wire c_rd4io = cb == OP_QUAD_IO_READ;
  wire c_read = c_rd1 | c_slow | c_rd2o | c_rd2io | c_rd4o | c_rd4io;
  wire c_erase = (cb == OP_SECTOR_ERASE) | (cb == OP_BLOCK32_ERASE) |
                 (cb == OP_BLOCK64_ERASE);
  wire c_prog = (cb == OP_DUAL_PAGE_PROGRAM) | (cb == OP_QUAD_PAGE_PROGRAM);
  wire c_stat = (cb == OP_STATUS_LOW_READ) | (cb == OP_STATUS_HIGH_READ);
  wire c_susp = (cb == OP_SUSPEND_A) | (cb == OP_SUSPEND_B) |
                (cb == OP_RESUME_A) | (cb == OP_RESUME_B);
  wire c_latch = (cb == OP_WRITE_ENABLE) | (cb == OP_WRITE_DISABLE) |
                 (cb == OP_VOLATILE_STATUS_ENABLE);
  wire c_wrsr = cb == OP_STATUS_WRITE;
  // while busy only status reads and suspend or resume get through
  wire c_ok_mod = ~wip & ~susp_q & wel_q & (c_erase | c_prog);
  wire c_ok_wrsr = ~wip & ~susp_q & (wel_q | vol_q) & c_wrsr;
  wire c_take_addr = (~wip & c_read) | c_ok_mod;
  wire c_take_end = c_susp | (~wip & c_latch);
  wire [2:0] c_addr_w = c_rd4io ? W4 : (c_rd2io ? W2 : W1);
  wire [2:0] c_out_w = (c_rd4o | c_rd4io) ? W4 :
                       ((c_rd2o | c_rd2io) ? W2 : W1);

  // decode of the opcode held for the rest of the frame
  wire o_erase = (op_q == OP_SECTOR_ERASE) | (op_q == OP_BLOCK32_ERASE) |
                 (op_q == OP_BLOCK64_ERASE);
  wire o_prog = (op_q == OP_DUAL_PAGE_PROGRAM) |
                (op_q == OP_QUAD_PAGE_PROGRAM);
  wire o_wrsr = op_q == OP_STATUS_WRITE;
  wire [2:0] o_prog_w = (op_q == OP_QUAD_PAGE_PROGRAM) ? W4 : W2;
  // security area is not programmable here, it reads as erased
  wire [7:0] fetch_byte =
    (op_q == OP_STATUS_LOW_READ) ? status_w[7:0] :
    (op_q == OP_STATUS_HIGH_READ) ? status_w[15:8] :
    (op_q == OP_SECURITY_REG_READ) ? ERASED_BYTE :
    mem_q[addr_q[MEM_AW-1:0]];
  wire prog_wr = byte_done & (phase_q == PH_DIN) & o_prog;
  wire commit = cs_rise & ok_q & (bitcnt_q == 4'h0);
  // a suspend on the final timer tick is dropped, the operation ends anyway
  wire susp_ok = ((busy_q == BS_PROG) | (busy_q == BS_ERASE)) &
                 (timer_q != '0);

  // front end: one frame per chip select, cleared while deselected
  always_ff @(posedge clk_i) begin
    if (sys_rst_i | ~cs_act) begin
      phase_q <= PH_CMD;
      op_q <= 8'h00;
      in_sr_q <= 8'h00;
      in_w_q <= W1;
      out_w_q <= W1;
      bitcnt_q <= 4'h0;
      cnt_q <= 2'h0;
      dummy_q <= 1'b0;
      ok_q <= 1'b0;
      load_q <= 1'b0;
      addr_q <= 24'h000000;
      out_sr_q <= 8'h00;
      sr_new_q <= 16'h0000;
    end else begin
      load_q <= 1'b0;
      if (sclk_rise & in_phase) begin
        in_sr_q <= in_next;
        bitcnt_q <= in_cnt[3] ? 4'h0 : in_cnt;
      end
      if (sclk_fall & (phase_q == PH_DOUT)) begin
        out_sr_q <= out_sr_q << out_w_q;
        bitcnt_q <= out_cnt[3] ? 4'h0 : out_cnt;
      end
      if (load_q | out_done) begin
        out_sr_q <= fetch_byte;
        if (op_q != OP_STATUS_LOW_READ && op_q != OP_STATUS_HIGH_READ) begin
          addr_q <= addr_q + 24'h000001;
        end
      end
      if (byte_done) begin
        case (phase_q)
          PH_CMD: begin
            op_q <= cb;
            out_w_q <= c_out_w;
            dummy_q <= ~c_slow;
            cnt_q <= 2'h0;
            if (c_take_addr) begin
              phase_q <= PH_ADDR;
              in_w_q <= c_addr_w;
            end else if (c_stat) begin
              phase_q <= PH_DOUT;
              load_q <= 1'b1;
            end else if (c_ok_wrsr) begin
              phase_q <= PH_DIN;
            end else if (c_take_end) begin
              phase_q <= PH_END;
              ok_q <= 1'b1;
            end else begin
              phase_q <= PH_IGNORE;
            end
          end
          PH_ADDR: begin
            addr_q <= {addr_q[15:0], in_next};
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == 2'h2) begin
              if (o_erase) begin
                phase_q <= PH_END;
                ok_q <= 1'b1;
              end else if (o_prog) begin
                phase_q <= PH_DIN;
                in_w_q <= o_prog_w;
              end else if (dummy_q) begin
                phase_q <= PH_DUMMY;
              end else begin
                phase_q <= PH_DOUT;
                load_q <= 1'b1;
              end
            end
          end
          PH_DUMMY: begin
            phase_q <= PH_DOUT;
            load_q <= 1'b1;
          end
          PH_DIN: begin
            if (o_prog) begin
              // page wrap keeps the burst inside its 256-byte page
              addr_q[7:0] <= addr_q[7:0] + 8'h01;
              ok_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 2'h1;
              if (cnt_q == 2'h0) begin
                sr_new_q[7:0] <= in_next;
              end else if (cnt_q == 2'h1) begin
                sr_new_q[15:8] <= in_next;
                ok_q <= 1'b1;
              end else begin
                ok_q <= 1'b0;
              end
            end
          end
          PH_END: ok_q <= 1'b0;
          default: phase_q <= PH_IGNORE;
        endcase
      end
    end
  end

  // latch, status bits and the program/erase timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_q <= BS_INIT;
      timer_q <= '0;
      sweep_q <= '0;
      wel_q <= 1'b0;
      vol_q <= 1'b0;
      susp_q <= 1'b0;
      sr_q <= SR_RESET;
    end else begin
      if (commit) begin
        case (op_q)
          OP_WRITE_ENABLE: wel_q <= 1'b1;
          OP_WRITE_DISABLE: wel_q <= 1'b0;
          OP_VOLATILE_STATUS_ENABLE: vol_q <= 1'b1;
          OP_STATUS_WRITE: begin
            sr_q <= sr_new_q & SR_WR_MASK;
            vol_q <= 1'b0;
            wel_q <= 1'b0;
          end
          OP_SUSPEND_A, OP_SUSPEND_B: begin
            // suspend lands at the frame end, far inside the latency bound
            if (susp_ok) begin
              susp_q <= 1'b1;
            end
          end
          OP_RESUME_A, OP_RESUME_B: susp_q <= 1'b0;
          default: begin
            if (o_erase) begin
              busy_q <= BS_ERASE;
              timer_q <= TMR_W'(ERASE_TIME_CYCLES);
            end else if (o_prog) begin
              busy_q <= BS_PROG;
              timer_q <= TMR_W'(PROG_TIME_CYCLES);
            end
          end
        endcase
      end
      case (busy_q)
        BS_INIT, BS_SWEEP: begin
          // whole array swept to erased; erase regions alias onto it
          sweep_q <= sweep_q + 1'b1;
          if (sweep_q == MEM_AW'(MEM_BYTES - 1)) begin
            busy_q <= BS_IDLE;
            if (busy_q == BS_SWEEP) begin
              wel_q <= 1'b0;
            end
          end
        end
        BS_PROG, BS_ERASE: begin
          if (~susp_q) begin
            if (timer_q != '0) begin
              timer_q <= timer_q - 1'b1;
            end else if (busy_q == BS_ERASE) begin
              busy_q <= BS_SWEEP;
              sweep_q <= '0;
            end else begin
              busy_q <= BS_IDLE;
              wel_q <= 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // array: programming only clears bits, sweep writes erased bytes
  always_ff @(posedge clk_i) begin
    if (busy_q == BS_INIT || busy_q == BS_SWEEP) begin
      mem_q[sweep_q] <= ERASED_BYTE;
    end else if (prog_wr) begin
      mem_q[addr_q[MEM_AW-1:0]] <= mem_q[addr_q[MEM_AW-1:0]] & in_next;
    end
  end

  // output lanes: single on io1, dual {io1,io0}, quad io3..io0
  wire [3:0] drv_d = (out_w_q == W4) ? out_sr_q[7:4] :
                     (out_w_q == W2) ? {2'b00, out_sr_q[7:6]} :
                     {2'b00, out_sr_q[7], 1'b0};
  wire [3:0] oe_d = (out_w_q == W4) ? 4'hf :
                    (out_w_q == W2) ? 4'h3 : 4'h2;

  // data changes on the falling clock so the host samples on the rise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i | ~cs_act | (phase_q != PH_DOUT)) begin
      io_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (sclk_fall) begin
      io_q <= drv_d;
      oe_q <= oe_d;
    end
  end

  assign io_o = io_q;
  assign io_oe_o = oe_q;
endmodule : sfce_top

// file: sfce_top_chk.sv
// pin-level assertions for the serial flash command engine
`timescale 1ns/10ps
module sfce_top_chk #(
  parameter int PROG_TIME_CYCLES = 50,
  parameter int ERASE_TIME_CYCLES = 80
) (
  // system
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // spi pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o
);
  logic sclk_q;
  logic cs_q;
  logic [5:0] rise_cnt_q;
  logic [5:0] rise_cnt_d;
  wire frame_start = ~cs_n_i & cs_q;
  wire sclk_rise = sclk_i & ~sclk_q;
  wire cnt_full = rise_cnt_q == 6'h3f;
  // raw count runs ahead of the synced pins, so lower bounds stay safe
  assign rise_cnt_d = frame_start ? 6'h00 :
    (sclk_rise && !cnt_full) ? rise_cnt_q + 6'h01 : rise_cnt_q;
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk_i;
    cs_q <= cs_n_i;
    rise_cnt_q <= sys_rst_i ? 6'h00 : rise_cnt_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst_i |=> io_oe_o == 4'h0 && io_o == 4'h0)
    else $error("outputs not quiet after reset");
  a_deselect_idle: assert property (
    cs_n_i [*5] |-> io_oe_o == 4'h0)
    else $error("drive while deselected");
  a_lane_pattern: assert property (
    io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable pattern");
  a_hold_high: assert property (
    (!cs_n_i && sclk_i) [*4] |-> $stable(io_o))
    else $error("data changed while clock high");
  a_no_early_drive: assert property (
    io_oe_o != 4'h0 |-> rise_cnt_q >= 6'h08)
    else $error("drive before opcode complete");
  a_quad_late: assert property (
    io_oe_o == 4'hf |-> rise_cnt_q >= 6'h10)
    else $error("quad drive too early");
  a_dual_late: assert property (
    io_oe_o == 4'h3 |-> rise_cnt_q >= 6'h18)
    else $error("dual drive too early");
  a_drive_selected: assert property ($rose(io_oe_o != 4'h0) |->
    $past(!cs_n_i, 2))
    else $error("drive started outside a frame");
  c_single: cover property ($rose(io_oe_o == 4'h2));
  c_dual: cover property ($rose(io_oe_o == 4'h3));
  c_quad: cover property ($rose(io_oe_o == 4'hf));
endmodule : sfce_top_chk

bind sfce_top sfce_top_chk #(
  .PROG_TIME_CYCLES(PROG_TIME_CYCLES),
  .ERASE_TIME_CYCLES(ERASE_TIME_CYCLES)
) sfce_top_chk_inst (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .cs_n_i(cs_n_i),
  .sclk_i(sclk_i),
  .io_i(io_i),
  .io_o(io_o),
  .io_oe_o(io_oe_o)
);

// file: sfce_host.sv
// host spi controller model, mode 0, one to four lanes
`timescale 1ns/10ps
module sfce_host (
  // system
  input wire logic clk_i,
  // spi pins
  input wire logic [3:0] pin_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o
);
  logic [3:0] last_q;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h0;
    last_q = 4'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold
  task automatic start;
    cs_n_o = 1'b0;
    hold(4);
  endtask : start
  task automatic stop;
    hold(4);
    cs_n_o = 1'b1;
    // released lines must not keep showing the last bit
    io_o = ~last_q;
    hold(8);
  endtask : stop
  task automatic put(input logic [7:0] b, input int w);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < 8 / w; i++) begin
      io_o = (w == 4) ? s[7:4] : (w == 2) ? {2'h0, s[7:6]} : {3'h0, s[7]};
      last_q = io_o;
      hold(4);
      sclk_o = 1'b1;
      hold(4);
      sclk_o = 1'b0;
      s = s << w;
    end
  endtask : put
  task automatic get(output logic [7:0] b, input int w);
    b = 8'h00;
    io_o = ~last_q;
    for (int i = 0; i < 8 / w; i++) begin
      hold(4);
      b = (w == 4) ? {b[3:0], pin_i} :
        (w == 2) ? {b[5:0], pin_i[1:0]} : {b[6:0], pin_i[1]};
      sclk_o = 1'b1;
      hold(4);
      sclk_o = 1'b0;
    end
  endtask : get
endmodule : sfce_host

// file: sfce_top_tb.sv
// self-checking bench for the serial flash command engine
`timescale 1ns/10ps
module sfce_top_tb;
  import sfce_pkg::*;
  localparam int PROG_T = 2000;
  localparam int ERASE_T = 3000;
  logic clk;
  logic sys_rst_i;
  logic cs_n;
  logic sclk;
  logic [3:0] host_io;
  logic [3:0] io_o;
  logic [3:0] io_oe_o;
  logic [3:0] pin;
  int n_fail;
  int check_count;
  assign pin = (io_oe_o & io_o) | (~io_oe_o & host_io);
  always #20 clk = ~clk;
  sfce_top #(.PROG_TIME_CYCLES(PROG_T), .ERASE_TIME_CYCLES(ERASE_T))
  sfce_top_inst (.clk_i(clk), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n),
    .sclk_i(sclk), .io_i(pin), .io_o(io_o), .io_oe_o(io_oe_o));
  sfce_host sfce_host_inst (.clk_i(clk), .pin_i(pin), .cs_n_o(cs_n),
    .sclk_o(sclk), .io_o(host_io));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op);
    sfce_host_inst.start();
    sfce_host_inst.put(op, 1);
  endtask : cmd
  task automatic op_only(input logic [7:0] op);
    cmd(op);
    sfce_host_inst.stop();
  endtask : op_only
  task automatic rd_reg(input logic [7:0] op, output logic [7:0] s);
    cmd(op);
    sfce_host_inst.get(s, 1);
    sfce_host_inst.stop();
  endtask : rd_reg
  task automatic adr(input logic [7:0] op, input logic [23:0] a, input int w);
    cmd(op);
    for (int i = 2; i >= 0; i--) sfce_host_inst.put(a[8*i +: 8], w);
  endtask : adr
  task automatic rd_arr(input logic [7:0] op, input int aw, dm, dw,
    input logic [23:0] a, output logic [7:0] b0, b1);
    adr(op, a, aw);
    if (dm != 0) sfce_host_inst.put(8'h00, aw);
    sfce_host_inst.get(b0, dw);
    sfce_host_inst.get(b1, dw);
    sfce_host_inst.stop();
  endtask : rd_arr
  task automatic wait_idle;
    logic [7:0] s;
    for (int i = 0; i < 200; i++) begin
      rd_reg(OP_STATUS_LOW_READ, s);
      if (s[SR_WIP_BIT] === 1'b0) return;
    end
    n_fail++;
    $display("BAD wait_idle expected 0 seen 1");
    finish_test();
  endtask : wait_idle
  task automatic prog(input logic [7:0] op, input logic [23:0] a,
    input int w, input logic [7:0] b);
    op_only(OP_WRITE_ENABLE);
    adr(op, a, 1);
    sfce_host_inst.put(b, w);
    sfce_host_inst.put(~b, w);
    sfce_host_inst.stop();
  endtask : prog
  task automatic wr_status(input logic [7:0] hi);
    op_only(OP_VOLATILE_STATUS_ENABLE);
    cmd(OP_STATUS_WRITE);
    sfce_host_inst.put(8'h00, 1);
    sfce_host_inst.put(hi, 1);
    sfce_host_inst.stop();
  endtask : wr_status
  task automatic t_reset;
    logic [7:0] s;
    check("oe_reset", {4'h0, io_oe_o}, 8'h00);
    repeat (1750) @(negedge clk);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("status_low_reset", s, 8'h00);
    rd_reg(OP_STATUS_HIGH_READ, s);
    check("status_high_reset", s, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_latch;
    logic [7:0] s;
    op_only(OP_WRITE_ENABLE);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wel_set", s, 8'h02);
    op_only(OP_VOLATILE_STATUS_ENABLE);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wel_kept", s, 8'h02);
    op_only(OP_WRITE_DISABLE);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wel_clear", s, 8'h00);
    op_only(OP_VOLATILE_STATUS_ENABLE);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wel_not_set", s, 8'h00);
    op_only(OP_WRITE_ENABLE);
    wr_status(8'h40);
    rd_reg(OP_STATUS_HIGH_READ, s);
    check("volatile_write", s, 8'h40);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wel_after_wrsr", s, 8'h00);
    wr_status(8'h00);
    $display("latch test done");
  endtask : t_latch
  task automatic t_prog;
    logic [7:0] s;
    logic [7:0] b1;
    prog(OP_QUAD_PAGE_PROGRAM, 24'h000010, 4, 8'ha5);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("prog_busy", s, 8'h03);
    wait_idle();
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wel_after_prog", s, 8'h00);
    prog(OP_DUAL_PAGE_PROGRAM, 24'h000020, 2, 8'h69);
    wait_idle();
    rd_arr(OP_SLOW_ARRAY_READ, 1, 0, 1, 24'h000020, s, b1);
    check("dual_prog", s, 8'h69);
    check("dual_prog_b1", b1, 8'h96);
    $display("program test done");
  endtask : t_prog
  task automatic t_reads;
    logic [7:0] ops[6];
    int aw[6];
    int dm[6];
    int dw[6];
    logic [7:0] b0;
    logic [7:0] b1;
    ops = '{OP_SLOW_ARRAY_READ, OP_FAST_ARRAY_READ, OP_DUAL_OUTPUT_READ,
      OP_DUAL_IO_READ, OP_QUAD_OUTPUT_READ, OP_QUAD_IO_READ};
    aw = '{1, 1, 1, 2, 1, 4};
    dm = '{0, 1, 1, 1, 1, 1};
    dw = '{1, 1, 2, 2, 4, 4};
    for (int i = 0; i < 6; i++) begin
      rd_arr(ops[i], aw[i], dm[i], dw[i], 24'h000010, b0, b1);
      check("read_b0", b0, 8'ha5);
      check("read_b1", b1, 8'h5a);
    end
    $display("read test done");
  endtask : t_reads
  task automatic t_erase;
    logic [7:0] ops[3];
    logic [7:0] s;
    logic [7:0] b1;
    ops = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
    for (int i = 0; i < 3; i++) begin
      prog(OP_QUAD_PAGE_PROGRAM, 24'h000010, 4, 8'h00);
      wait_idle();
      op_only(OP_WRITE_ENABLE);
      adr(ops[i], 24'h000010, 1);
      sfce_host_inst.stop();
      rd_reg(OP_STATUS_LOW_READ, s);
      check("erase_busy", s, 8'h03);
      wait_idle();
      rd_arr(OP_SLOW_ARRAY_READ, 1, 0, 1, 24'h000010, s, b1);
      check("erased", s, 8'hff);
    end
    $display("erase test done");
  endtask : t_erase
  task automatic susp(input logic [7:0] so, ro, hi);
    logic [7:0] s;
    op_only(so);
    rd_reg(OP_STATUS_HIGH_READ, s);
    check("suspended", s, hi);
    rd_reg(OP_STATUS_LOW_READ, s);
    check("wip_paused", s, 8'h02);
    op_only(ro);
    repeat (5000) @(negedge clk);
    rd_reg(OP_STATUS_HIGH_READ, s);
    check("resumed", s, 8'h00);
    wait_idle();
  endtask : susp
  task automatic t_susp;
    op_only(OP_WRITE_ENABLE);
    adr(OP_SECTOR_ERASE, 24'h000000, 1);
    sfce_host_inst.stop();
    susp(OP_SUSPEND_A, OP_RESUME_A, 8'h80);
    prog(OP_QUAD_PAGE_PROGRAM, 24'h000030, 4, 8'h11);
    susp(OP_SUSPEND_B, OP_RESUME_B, 8'h04);
    $display("suspend test done");
  endtask : t_susp
  task automatic t_misc;
    logic [7:0] s;
    logic [7:0] b1;
    rd_arr(OP_SECURITY_REG_READ, 1, 1, 1, 24'h001000, s, b1);
    check("security", s, 8'hff);
    cmd(8'h9f);
    sfce_host_inst.put(8'h00, 1);
    sfce_host_inst.put(8'h00, 1);
    check("ignored_oe", {4'h0, io_oe_o}, 8'h00);
    sfce_host_inst.stop();
    rd_reg(OP_STATUS_LOW_READ, s);
    check("after_unknown", s, 8'h00);
    $display("misc test done");
  endtask : t_misc
  initial begin
    clk = 1'b0;
    sys_rst_i = 1'b1;
    n_fail = 0;
    check_count = 0;
    repeat (20) @(negedge clk);
    sys_rst_i = 1'b0;
    t_reset();
    t_latch();
    t_prog();
    t_reads();
    t_erase();
    t_susp();
    t_misc();
    finish_test();
  end
endmodule : sfce_top_tb
